// ### verilog/block_xfer_pkg.sv
// shared constants and types for the block transfer address generator
// assumes the instruction word arrives already fetched, on the core clock
package block_xfer_pkg;

    // ------------------------------------------------------------
    // instruction word fields
    // ------------------------------------------------------------
    localparam int COND_HI     = 31;
    localparam int COND_LO     = 28;
    localparam int PRE_BIT     = 24;
    localparam int UP_BIT      = 23;
    localparam int SPECIAL_BIT = 22;
    localparam int WB_BIT      = 21;
    localparam int LOAD_BIT    = 20;
    localparam int BASE_HI     = 19;
    localparam int BASE_LO     = 16;
    localparam int MASK_HI     = 15;
    localparam int MASK_LO     = 0;
    localparam int TOP_REG     = 15;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int          MASK_W      = 16;
    localparam int          CNT_W       = 5;
    localparam logic [31:0] WORD_STEP   = 32'h0000_0004;
    localparam logic [31:0] WORD_RESET  = 32'h0000_0000;
    localparam logic [4:0]  CNT_RESET   = 5'h00;

    // ------------------------------------------------------------
    // addressing modes, coded as {pre, up}
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DEC_AFTER  = 2'h0,
        INC_AFTER  = 2'h1,
        DEC_BEFORE = 2'h2,
        INC_BEFORE = 2'h3
    } xfer_mode_e;

    // stack aliases: loads and stores see full/empty reversed
    localparam xfer_mode_e LOAD_FULL_ASCENDING    = DEC_AFTER;
    localparam xfer_mode_e LOAD_FULL_DESCENDING   = INC_AFTER;
    localparam xfer_mode_e LOAD_EMPTY_ASCENDING   = DEC_BEFORE;
    localparam xfer_mode_e LOAD_EMPTY_DESCENDING  = INC_BEFORE;
    localparam xfer_mode_e STORE_EMPTY_DESCENDING = DEC_AFTER;
    localparam xfer_mode_e STORE_EMPTY_ASCENDING  = INC_AFTER;
    localparam xfer_mode_e STORE_FULL_DESCENDING  = DEC_BEFORE;
    localparam xfer_mode_e STORE_FULL_ASCENDING   = INC_BEFORE;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } gen_state_e;

    typedef struct packed {
        logic [31:0] addr;
        logic [3:0]  reg_idx;
        logic        load;
        logic        user_bank;
        logic        last;
    } beat_s;

    typedef struct packed {
        logic [3:0]  cond;
        logic [2:0]  fixed;
        logic        pre;
        logic        up;
        logic        special;
        logic        writeback;
        logic        load;
        logic [3:0]  base_reg;
        logic [15:0] mask;
    } instr_s;

endpackage

// ### verilog/block_xfer_addr_gen.sv
// address generator for multi-register loads and stores
// assumes all inputs come from core logic on clk_i; beats drain through a
// two-entry buffer so a stalled memory path loses no address
//
// Notes on behaviour
// - pre clear: base word inside the range
// - pre set: base word just outside range
// - up bit one counts upward, zero downward
// - load with program counter and special: restore
// - special otherwise: privileged uses user bank
// - special load in user mode: undefined
// - writeback adds or subtracts four per register
// - writeback only when condition passes
// - load bit one is load, zero store
// - mask bit n selects register n
// - increment after: base to base+4n-4
// - increment before: base+4 to base+4n
// - decrement after: base-4n+4 to base
// - decrement before: base-4n to base-4
// - one address per register, rising by four
// - lowest register gets lowest address
// - stack aliases map onto fixed modes
`timescale 1ns/100ps

module block_xfer_addr_gen
    import block_xfer_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        req_valid_i,
    output logic             req_ready_o,
    input  wire logic [31:0] instr_i,
    input  wire logic [31:0] base_value_i,
    input  wire logic        cond_pass_i,
    input  wire logic        privileged_i,
    input  wire logic        user_or_system_i,
    input  wire logic [31:0] saved_status_word_i,
    output logic             beat_valid_o,
    input  wire logic        beat_ready_i,
    output beat_s            beat_o,
    output logic [31:0]      start_addr_o,
    output logic [31:0]      end_addr_o,
    output logic [4:0]       reg_count_o,
    output xfer_mode_e       mode_o,
    output logic             wb_valid_o,
    output logic [3:0]       wb_reg_o,
    output logic [31:0]      wb_value_o,
    output logic             status_load_o,
    output logic [31:0]      current_status_word_o,
    output logic             unpredictable_o
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    instr_s      ins_w;
    logic        take_w;
    logic [4:0]  ones_sum_w [0:MASK_W];
    logic [4:0]  count_w;
    logic [31:0] span_w;
    logic [31:0] start_w;
    logic [31:0] end_w;
    logic [31:0] wb_next_w;
    logic        top_listed_w;
    logic        restore_w;
    logic        user_bank_w;
    logic        odd_form_w;
    xfer_mode_e  mode_w;

    assign ins_w  = instr_s'(instr_i);
    assign take_w = req_valid_i & req_ready_o;
    assign mode_w = xfer_mode_e'({ins_w.pre, ins_w.up});

    // register count, built as a running sum over the mask
    assign ones_sum_w[0] = CNT_RESET;
    for (genvar j = 0; j < MASK_W; j++) begin : g_pop
        assign ones_sum_w[j+1] = ones_sum_w[j] + {4'h0, ins_w.mask[j]};
    end
    assign count_w = ones_sum_w[MASK_W];
    assign span_w  = {25'h0, count_w, 2'b00};

    // pre bit picks whether the base word is inside the range
    always_comb begin
        case (mode_w)
            INC_AFTER: begin
                start_w = base_value_i;
                end_w   = base_value_i + span_w - WORD_STEP;
            end
            INC_BEFORE: begin
                start_w = base_value_i + WORD_STEP;
                end_w   = base_value_i + span_w;
            end
            DEC_AFTER: begin
                start_w = base_value_i - span_w + WORD_STEP;
                end_w   = base_value_i;
            end
            DEC_BEFORE: begin
                start_w = base_value_i - span_w;
                end_w   = base_value_i - WORD_STEP;
            end
            default: begin
                start_w = base_value_i;
                end_w   = base_value_i;
            end
        endcase
    end

    assign wb_next_w    = ins_w.up ? base_value_i + span_w : base_value_i - span_w;
    assign top_listed_w = ins_w.mask[TOP_REG];
    assign restore_w    = ins_w.load & ins_w.special & top_listed_w;
    assign user_bank_w  = ins_w.special & ~restore_w & privileged_i;
    // both cases are only flagged; the range is still generated as usual
    assign odd_form_w   = (ins_w.load & ins_w.special & user_or_system_i)
                        | (count_w == CNT_RESET);

    // ------------------------------------------------------------
    // beat sequencer
    // ------------------------------------------------------------
    gen_state_e  state_q, state_d;
    logic [15:0] rem_q;
    logic [31:0] addr_q;
    logic        load_q;
    logic        ubank_q;
    logic [15:0] lowest_w;
    logic [15:0] rem_next_w;
    logic [3:0]  idx_w;
    logic        push_w;
    logic        fill_ready_w;
    logic        gen_last_w;
    beat_s       gen_beat_w;

    // lowest set bit first, so register order follows address order
    assign lowest_w   = rem_q & (~rem_q + 16'h0001);
    assign rem_next_w = rem_q & ~lowest_w;
    for (genvar b = 0; b < 4; b++) begin : g_enc
        logic [15:0] sel_w;
        for (genvar j = 0; j < MASK_W; j++) begin : g_bit
            assign sel_w[j] = lowest_w[j] & (((j >> b) % 2) == 1);
        end
        assign idx_w[b] = |sel_w;
    end

    assign push_w     = (state_q == ST_RUN) & fill_ready_w;
    assign gen_last_w = (rem_next_w == 16'h0000);
    assign gen_beat_w = '{addr: addr_q, reg_idx: idx_w, load: load_q,
                          user_bank: ubank_q, last: gen_last_w};

    always_comb begin
        case (state_q)
            ST_IDLE: state_d = (take_w & cond_pass_i & (count_w != CNT_RESET))
                             ? ST_RUN : ST_IDLE;
            ST_RUN:  state_d = (push_w & gen_last_w) ? ST_IDLE : ST_RUN;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q     <= ST_IDLE;
            req_ready_o <= 1'b1;
        end else begin
            state_q     <= state_d;
            req_ready_o <= (state_d == ST_IDLE);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rem_q   <= 16'h0000;
            addr_q  <= WORD_RESET;
            load_q  <= 1'b0;
            ubank_q <= 1'b0;
        end else if (take_w) begin
            rem_q   <= cond_pass_i ? ins_w.mask : 16'h0000;
            addr_q  <= start_w;
            load_q  <= ins_w.load;
            ubank_q <= user_bank_w;
        end else if (push_w) begin
            rem_q  <= rem_next_w;
            addr_q <= addr_q + WORD_STEP;
        end
    end

    // ------------------------------------------------------------
    // per-instruction results
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            start_addr_o          <= WORD_RESET;
            end_addr_o            <= WORD_RESET;
            reg_count_o           <= CNT_RESET;
            mode_o                <= DEC_AFTER;
            wb_valid_o            <= 1'b0;
            wb_reg_o              <= 4'h0;
            wb_value_o            <= WORD_RESET;
            status_load_o         <= 1'b0;
            current_status_word_o <= WORD_RESET;
            unpredictable_o       <= 1'b0;
        end else begin
            wb_valid_o      <= take_w & cond_pass_i & ins_w.writeback;
            status_load_o   <= take_w & cond_pass_i & restore_w;
            unpredictable_o <= take_w & odd_form_w;
            if (take_w) begin
                start_addr_o <= start_w;
                end_addr_o   <= end_w;
                reg_count_o  <= count_w;
                mode_o       <= mode_w;
                wb_reg_o     <= ins_w.base_reg;
                wb_value_o   <= wb_next_w;
            end
            if (take_w & cond_pass_i & restore_w) begin
                current_status_word_o <= saved_status_word_i;
            end
        end
    end

    // ------------------------------------------------------------
    // two-entry output buffer
    // ------------------------------------------------------------
    // head feeds the port directly; tail absorbs one beat during a stall
    logic  head_v_q;
    logic  tail_v_q;
    beat_s tail_q;
    logic  pop_w;

    assign fill_ready_w = ~tail_v_q;
    assign pop_w        = beat_valid_o & beat_ready_i;
    assign head_v_q     = beat_valid_o;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            beat_valid_o <= 1'b0;
            beat_o       <= '0;
            tail_v_q     <= 1'b0;
            tail_q       <= '0;
        end else begin
            beat_valid_o <= tail_v_q | push_w | (head_v_q & ~pop_w);
            if (!head_v_q || pop_w) begin
                beat_o <= tail_v_q ? tail_q : gen_beat_w;
            end
            if (tail_v_q) begin
                tail_v_q <= ~pop_w;
            end else begin
                tail_v_q <= push_w & head_v_q & ~pop_w;
            end
            if (!tail_v_q && push_w) begin
                tail_q <= gen_beat_w;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    logic [31:0] prev_addr_q;
    logic [3:0]  prev_idx_q;
    logic        prev_open_q;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_addr_q <= WORD_RESET;
            prev_idx_q  <= 4'h0;
            prev_open_q <= 1'b0;
        end else if (pop_w) begin
            prev_addr_q <= beat_o.addr;
            prev_idx_q  <= beat_o.reg_idx;
            prev_open_q <= ~beat_o.last;
        end
    end

    inc_after_range_a: assert property (
        take_w && mode_w == INC_AFTER |=> start_addr_o == $past(base_value_i)
            && end_addr_o == $past(base_value_i) + {25'h0, reg_count_o, 2'b00} - 32'h4)
        else $error("increment-after range wrong");
    inc_before_range_a: assert property (
        take_w && mode_w == INC_BEFORE |=> start_addr_o == $past(base_value_i) + 32'h4
            && end_addr_o == $past(base_value_i) + {25'h0, reg_count_o, 2'b00})
        else $error("increment-before range wrong");
    dec_after_range_a: assert property (
        take_w && mode_w == DEC_AFTER |=> end_addr_o == $past(base_value_i)
            && start_addr_o == $past(base_value_i) - {25'h0, reg_count_o, 2'b00} + 32'h4)
        else $error("decrement-after range wrong");
    dec_before_range_a: assert property (
        take_w && mode_w == DEC_BEFORE |=> end_addr_o == $past(base_value_i) - 32'h4
            && start_addr_o == $past(base_value_i) - {25'h0, reg_count_o, 2'b00})
        else $error("decrement-before range wrong");
    stack_alias_a: assert property (
        take_w && !ins_w.load && mode_w == STORE_FULL_DESCENDING
            |=> end_addr_o == $past(base_value_i) - 32'h4)
        else $error("full-descending store alias wrong");
    reg_count_a: assert property (
        take_w |=> reg_count_o == 5'($countones($past(instr_i[15:0]))))
        else $error("register count wrong");
    addr_step_a: assert property (
        pop_w && prev_open_q |-> beat_o.addr == prev_addr_q + 32'h4)
        else $error("addresses not consecutive");
    reg_order_a: assert property (
        pop_w && prev_open_q |-> beat_o.reg_idx > prev_idx_q)
        else $error("register order not rising");
    // the beat must name a listed register with no lower one still pending
    mask_select_a: assert property (
        push_w |-> rem_q[idx_w] && (rem_q & ((16'h0001 << idx_w) - 16'h0001)) == 16'h0000)
        else $error("beat for unselected register");
    writeback_value_a: assert property (
        take_w && cond_pass_i && ins_w.writeback |=> wb_valid_o
            && wb_value_o == ($past(ins_w.up)
                ? $past(base_value_i) + {25'h0, reg_count_o, 2'b00}
                : $past(base_value_i) - {25'h0, reg_count_o, 2'b00}))
        else $error("writeback value wrong");
    writeback_gate_a: assert property (
        !(take_w && cond_pass_i && ins_w.writeback) |=> !wb_valid_o)
        else $error("writeback without cause");
    status_copy_a: assert property (
        take_w && cond_pass_i && restore_w
            |=> status_load_o && current_status_word_o == $past(saved_status_word_i))
        else $error("status word not restored");
    user_bank_a: assert property (
        take_w |=> ubank_q == $past(ins_w.special && privileged_i
            && !(ins_w.load && ins_w.mask[15])))
        else $error("user bank selection wrong");
    odd_form_a: assert property (
        take_w && ins_w.load && ins_w.special && user_or_system_i |=> unpredictable_o)
        else $error("odd form not flagged");

    // a stalled beat must neither vanish nor change under the receiver
    beat_hold_a: assert property (
        beat_valid_o && !beat_ready_i |=> beat_valid_o && $stable(beat_o))
        else $error("stalled beat lost or changed");
    fail_quiet_a: assert property (
        take_w && !cond_pass_i |=> req_ready_o && !wb_valid_o && !status_load_o)
        else $error("failed condition still acted");
    busy_after_take_a: assert property (
        take_w && cond_pass_i && count_w != CNT_RESET |=> !req_ready_o)
        else $error("ready while beats pending");
    load_flag_a: assert property (
        take_w |=> load_q == $past(instr_i[LOAD_BIT]))
        else $error("load flag wrong");

    // ------------------------------------------------------------
    // coverage of the main scenarios
    // ------------------------------------------------------------
    load_inc_after_c:   cover property (take_w && cond_pass_i && ins_w.load
                                        && mode_w == INC_AFTER);
    store_dec_before_c: cover property (take_w && cond_pass_i && !ins_w.load
                                        && ins_w.writeback && mode_w == DEC_BEFORE);
    stall_c:            cover property (beat_valid_o && !beat_ready_i && tail_v_q);
    restore_c:          cover property (status_load_o);
    odd_form_c:         cover property (unpredictable_o);

endmodule

// ### tb/mem_path_model.sv
// memory access path seen from the beat side of the address generator
// assumes beats arrive on clk_i; the bench reads and clears the log queue
`timescale 1ns/100ps

module mem_path_model
    import block_xfer_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  arst_n_i,
    input  wire logic  slow_i,
    input  wire logic  beat_valid_i,
    input  wire beat_s beat_i,
    output logic       beat_ready_o
);
    logic [2:0] tick_q;
    beat_s      got[$];

    // slow mode takes one beat in eight, so the two-entry buffer fills up
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tick_q       <= 3'h0;
            beat_ready_o <= 1'b0;
        end else begin
            tick_q       <= tick_q + 3'h1;
            beat_ready_o <= !slow_i || (tick_q == 3'h6);
        end
    end

    always @(posedge clk_i) begin
        if (arst_n_i && beat_valid_i && beat_ready_o) begin
            got.push_back(beat_i);
        end
    end
endmodule

// ### tb/block_transfer_address_gen_bench.sv
// self-checking bench for the block transfer address generator
// assumes the memory path model logs every beat it takes
`timescale 1ns/100ps

module block_transfer_address_gen_bench
    import block_xfer_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        req_valid_i = 1'b0;
    logic [31:0] instr_i = 32'h0;
    logic [31:0] base_value_i = 32'h0;
    logic        cond_pass_i = 1'b0;
    logic        privileged_i = 1'b0;
    logic        user_or_system_i = 1'b0;
    logic [31:0] saved_status_word_i = 32'h0;
    logic        slow = 1'b0;
    logic        req_ready_o, beat_valid_o, beat_ready, wb_valid_o;
    logic        status_load_o, unpredictable_o;
    beat_s       beat_o;
    logic [31:0] start_addr_o, end_addr_o, wb_value_o, current_status_word_o;
    logic [4:0]  reg_count_o;
    logic [3:0]  wb_reg_o;
    xfer_mode_e  mode_o;
    int          n_mismatch = 0;
    int          n_checks = 0;
    logic [15:0] masks [8] = '{16'h0001, 16'h8005, 16'h00F0, 16'hFFFF,
                               16'h1234, 16'h8000, 16'h0180, 16'h7FFE};

    block_xfer_addr_gen block_xfer_addr_gen_i (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .instr_i(instr_i), .base_value_i(base_value_i),
        .cond_pass_i(cond_pass_i), .privileged_i(privileged_i),
        .user_or_system_i(user_or_system_i), .saved_status_word_i(saved_status_word_i),
        .beat_valid_o(beat_valid_o), .beat_ready_i(beat_ready), .beat_o(beat_o),
        .start_addr_o(start_addr_o), .end_addr_o(end_addr_o), .reg_count_o(reg_count_o),
        .mode_o(mode_o), .wb_valid_o(wb_valid_o), .wb_reg_o(wb_reg_o),
        .wb_value_o(wb_value_o), .status_load_o(status_load_o),
        .current_status_word_o(current_status_word_o), .unpredictable_o(unpredictable_o));

    mem_path_model mem_path_model_i (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .slow_i(slow),
        .beat_valid_i(beat_valid_o), .beat_i(beat_o), .beat_ready_o(beat_ready));

    // ------------------------------------------------------------
    // compare and closing tasks
    // ------------------------------------------------------------
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_beat(input beat_s got, input beat_s exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // one instruction; f is {pre, up, special, writeback, load}
    // ------------------------------------------------------------
    task automatic xfer(input logic [4:0] f, input logic [15:0] mask, input logic [31:0] base,
                        input logic cp, input logic pv, input logic us);
        int          n;
        int          k;
        logic [31:0] st;
        logic [31:0] en;
        logic [3:0]  idx[$];
        beat_s       eb;
        for (k = 0; k < 16; k++) begin
            if (mask[k]) begin
                idx.push_back(4'(k));
            end
        end
        n = idx.size();
        case (f[4:3])
            2'h0: st = base - 32'(4 * n) + 32'h4;
            2'h1: st = base;
            2'h2: st = base - 32'(4 * n);
            default: st = base + 32'h4;
        endcase
        en = st + 32'(4 * n) - 32'h4;
        @(posedge clk_i);
        while (req_ready_o !== 1'b1) @(posedge clk_i);
        req_valid_i         <= 1'b1;
        instr_i             <= {4'hE, 3'h4, f, 4'h9, mask};
        base_value_i        <= base;
        cond_pass_i         <= cp;
        privileged_i        <= pv;
        user_or_system_i    <= us;
        saved_status_word_i <= ~base;
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        #1;
        chk_val(32'(req_ready_o), 32'(!(cp && n != 0)));
        if (n != 0) begin
            chk_val(start_addr_o, st);
            chk_val(end_addr_o, en);
            chk_val(32'(wb_valid_o), 32'(cp & f[1]));
            if (cp & f[1]) begin
                chk_val(wb_value_o, f[3] ? base + 32'(4 * n) : base - 32'(4 * n));
                chk_val(32'(wb_reg_o), 32'h9);
            end
        end
        chk_val(32'(reg_count_o), 32'(n));
        chk_val(32'(mode_o), 32'(f[4:3]));
        chk_val(32'(status_load_o), 32'(cp & f[0] & f[2] & mask[15]));
        if (cp & f[0] & f[2] & mask[15]) begin
            chk_val(current_status_word_o, ~base);
        end
        chk_val(32'(unpredictable_o), 32'((f[0] & f[2] & us) | (n == 0)));
        for (k = 0; k < 400; k++) begin
            if (mem_path_model_i.got.size() == (cp ? n : 0) && req_ready_o === 1'b1) break;
            @(posedge clk_i);
            #1;
        end
        repeat (2) @(posedge clk_i);
        #1;
        chk_val(32'(mem_path_model_i.got.size()), 32'(cp ? n : 0));
        chk_val(32'(wb_valid_o), 32'h0);
        for (k = 0; k < mem_path_model_i.got.size() && k < n; k++) begin
            eb = '{addr: st + 32'(4 * k), reg_idx: idx[k], load: f[0],
                   user_bank: f[2] & pv & ~(f[0] & mask[15]), last: k == n - 1};
            chk_beat(mem_path_model_i.got[k], eb);
        end
        mem_path_model_i.got.delete();
    endtask

    initial begin
        forever begin
            #2 clk_i = ~clk_i;
        end
    end

    // far longer than the whole sequence needs
    initial begin
        #80000;
        n_mismatch++;
        results();
    end

    initial begin
        repeat (10) @(posedge clk_i);
        chk_val(32'(req_ready_o), 32'h1);
        chk_val(32'(beat_valid_o), 32'h0);
        arst_n_i <= 1'b1;
        for (int m = 0; m < 8; m++) begin
            xfer({m[2:1], 2'b01, m[0]}, masks[m], 32'h1000 + 32'(m) * 32'h100,
                 1'b1, 1'b1, 1'b0);
        end
        xfer(5'b01010, 16'h0003, 32'h2000, 1'b0, 1'b1, 1'b0);
        xfer(5'b01010, 16'h0003, 32'h2000, 1'b0, 1'b1, 1'b0);
        xfer(5'b11000, 16'h0C00, 32'h2100, 1'b1, 1'b1, 1'b0);
        xfer(5'b01101, 16'h8002, 32'h2200, 1'b1, 1'b1, 1'b0);
        xfer(5'b00101, 16'h0006, 32'h2300, 1'b1, 1'b1, 1'b0);
        xfer(5'b10100, 16'h0300, 32'h2400, 1'b1, 1'b1, 1'b0);
        xfer(5'b10100, 16'h0300, 32'h2400, 1'b1, 1'b0, 1'b1);
        xfer(5'b01101, 16'h0003, 32'h2500, 1'b1, 1'b0, 1'b1);
        xfer(5'b01011, 16'h0000, 32'h2600, 1'b1, 1'b1, 1'b0);
        @(posedge clk_i);
        slow <= 1'b1;
        xfer(5'b10011, 16'hFFFF, 32'h0000_0040, 1'b1, 1'b1, 1'b0);
        @(posedge clk_i);
        slow <= 1'b0;
        results();
    end
endmodule
